// ===== logic/scs_stage.sv
// The address map and register access over APB were decided locally.
`timescale 1ns/1ps
// Synchronism-check stage with APB settings and status registers.

// Summary of operation
// - Synchronized only when all three differences fit.
// - Each side live or dead by thresholds.
// - Voltage-condition setting adds live/dead requirement.
// - Monitor frequency, angle and magnitude per channel.
// - Report condition code blocked, ok, bypass, checks.
// - Report voltage state of both sides.
// - Magnitude difference in 0.01 percent steps.
// - Angle difference in 0.01 degree steps.
// - Frequency difference in 0.001 Hz steps.
// - Switching state shown only when timed close.
// - Estimate time left to breaker closing.
// - Estimate time for one full relative rotation.
// - Report present relative placement in millidegrees.
// - Sample blocking input at each cycle start.
// - Sync-ok when synchronized and not blocked.
// - Blocked at sync onset gives blocked output.
// - Blocking after sync-ok drops sync-ok.
// - On-start mode checks only while start active.
// - Setting picks bus or line as reference.
// - Forcing to normal, blocked or ok when enabled.
module scs_stage
  import scs_pkg::*;
(
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RESET,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Measurements from the front end, bus side and line side.
  input wire logic [15:0] BUS_MAG,
  input wire logic [15:0] LINE_MAG,
  input wire logic signed [15:0] BUS_ANG,
  input wire logic signed [15:0] LINE_ANG,
  input wire logic signed [19:0] BUS_FRQ,
  input wire logic signed [19:0] LINE_FRQ,
  input wire logic MEAS_VALID,
  // Control inputs from the blocking matrix and input control.
  input wire logic BLOCK_IN,
  input wire logic CHECK_START_INPUT,
  // Stage results.
  output logic SYNC_GOOD_OUT,
  output logic BLOCKED_OUT
);

  // All state of the stage.
  typedef struct packed {
    logic [31:0] ctrl;
    logic [15:0] mag_max;
    logic [15:0] ang_max;
    logic [15:0] frq_max;
    logic [15:0] live_thr;
    logic [15:0] dead_thr;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] blk_sync;
    logic blk;
    logic [1:0] start_sync;
    logic sync_prev;
    logic sync_good;
    logic blocked;
    scs_cond_t cond;
    scs_vstate_t vstate;
    scs_sw_t sw;
    logic signed [15:0] mag_diff;
    logic signed [15:0] ang_diff;
    logic signed [19:0] frq_diff;
    logic signed [15:0] ang_prev;
    logic [16:0] close_time;
    logic [16:0] rot_time;
    logic signed [19:0] placement;
  } scs_state_t;

  scs_state_t st_reg; // Registered state.
  scs_state_t st_next; // Next state.

  // Live/dead flags of both sides, one cycle behind the magnitudes.
  logic bus_live; // Bus side is live.
  logic bus_dead; // Bus side is dead.
  logic line_live; // Line side is live.
  logic line_dead; // Line side is dead.

  // Bus side classifier.
  scs_side_class u_bus (
    .clk(REF_CLK),
    .rst(RESET),
    .volt(BUS_MAG),
    .live_thr(st_reg.live_thr),
    .dead_thr(st_reg.dead_thr),
    .live(bus_live),
    .dead(bus_dead)
  );

  // Line side classifier.
  scs_side_class u_line (
    .clk(REF_CLK),
    .rst(RESET),
    .volt(LINE_MAG),
    .live_thr(st_reg.live_thr),
    .dead_thr(st_reg.dead_thr),
    .live(line_live),
    .dead(line_dead)
  );

  // Absolute value helper for the difference checks.
  function automatic logic [19:0] abs20(input logic signed [19:0] v);
    abs20 = v[19] ? 20'(-v) : 20'(v);
  endfunction : abs20

  // Next-state logic: bus slave, checks and estimates.
  always_comb begin
    logic signed [16:0] mdiff;
    logic signed [16:0] adiff;
    logic signed [20:0] fdiff;
    logic ref_live, ref_dead, oth_live, oth_dead;
    logic vcond_ok, mag_ok, ang_ok, frq_ok, sync_now, enable, start_ok;
    logic [3:0] vsel;
    logic [19:0] frq_abs;
    logic signed [16:0] ang_step;
    logic [31:0] rot_calc;
    // The close-time product needs 48 bits: a full turn times the scale passes 32.
    logic [47:0] close_calc;
    logic [31:0] ang_abs;
    // Every field holds unless a branch below changes it.
    st_next = st_reg;
    // Helpers used only on a measurement update start from zero.
    ang_step = '0;
    frq_abs = '0;
    rot_calc = '0;
    close_calc = '0;
    ang_abs = '0;
    // Signed differences, bus side minus line side, one bit wider than the inputs.
    mdiff = signed'(17'(BUS_MAG)) - signed'(17'(LINE_MAG));
    adiff = 17'(BUS_ANG) - 17'(LINE_ANG);
    fdiff = 21'(BUS_FRQ) - 21'(LINE_FRQ);
    // With the enable low the stage reports not monitored, and bypass unless forced.
    enable = st_reg.ctrl[CTRL_ENABLE_BIT];
    vsel = st_reg.ctrl[CTRL_VCOND_LSB +: 4];
    // Two-stage synchronisers; the first stage feeds only the second.
    st_next.blk_sync = {st_reg.blk_sync[0], BLOCK_IN};
    st_next.start_sync = {st_reg.start_sync[0], CHECK_START_INPUT};
    // Blocking is taken at the start of the cycle and used below.
    st_next.blk = st_reg.blk_sync[1];
    // Choose which side is the reference for live/dead.
    if (st_reg.ctrl[CTRL_LINE_REF_BIT]) begin
      ref_live = line_live;
      ref_dead = line_dead;
      oth_live = bus_live;
      oth_dead = bus_dead;
    end else begin
      ref_live = bus_live;
      ref_dead = bus_dead;
      oth_live = line_live;
      oth_dead = line_dead;
    end
    // Voltage state of both sides, reference side first.
    if (!enable) begin
      st_next.vstate = VST_NOT_MON;
    end else if (ref_dead && oth_dead) begin
      st_next.vstate = VST_DEAD_DEAD;
    end else if (ref_live && oth_dead) begin
      st_next.vstate = VST_LIVE_DEAD;
    end else if (ref_dead && oth_live) begin
      st_next.vstate = VST_DEAD_LIVE;
    end else if (ref_live && oth_live) begin
      st_next.vstate = VST_LIVE_LIVE;
    end else begin
      st_next.vstate = VST_UNDEFINED;
    end
    // Each selected combination bit allows one live/dead combination.
    vcond_ok = (vsel[0] && ref_dead && oth_dead) || (vsel[1] && ref_live && oth_dead)
      || (vsel[2] && ref_dead && oth_live) || (vsel[3] && ref_live && oth_live);
    // Independent difference checks against the held limits.
    mag_ok = abs20(20'(mdiff)) <= 20'(st_reg.mag_max);
    ang_ok = abs20(20'(adiff)) <= 20'(st_reg.ang_max);
    frq_ok = abs20(20'(fdiff)) <= 20'(st_reg.frq_max);
    // In on-start mode the synchronised start input must stand high.
    start_ok = !st_reg.ctrl[CTRL_START_ON_BIT] || st_reg.start_sync[1];
    sync_now = enable && start_ok && vcond_ok && mag_ok && ang_ok && frq_ok;
    // Differences are refreshed with each measurement update.
    if (MEAS_VALID) begin
      st_next.mag_diff = 16'(mdiff);
      st_next.ang_diff = 16'(adiff);
      st_next.frq_diff = 20'(fdiff);
      st_next.ang_prev = 16'(adiff);
      st_next.placement = 20'(20'(adiff) * 20'sd10);
      ang_step = 17'(adiff) - 17'(st_reg.ang_prev);
      frq_abs = abs20(20'(fdiff));
      ang_abs = 32'(abs20(20'(adiff)));
      // Rotation period in 5 ms steps: 1e6 mHz*ms / (f_mHz * 5 ms).
      rot_calc = (frq_abs == 20'h0) ? 32'(TIME_MAX_STEPS)
        : 32'(200000) / 32'(frq_abs);
      close_calc = (frq_abs == 20'h0) ? 48'(TIME_MAX_STEPS)
        : (48'(ang_abs) * 48'(200000)) / (48'(FULL_TURN_CDEG) * 48'(frq_abs));
      st_next.rot_time = (rot_calc > 32'(TIME_MAX_STEPS)) ? TIME_MAX_STEPS
        : 17'(rot_calc);
      st_next.close_time = (close_calc > 48'(TIME_MAX_STEPS)) ? TIME_MAX_STEPS
        : 17'(close_calc);
      // Switching state from whether the angle gap shrinks or grows.
      if (!st_reg.ctrl[CTRL_TIMED_CLOSE_BIT]) begin
        st_next.sw = SW_NONE;
      end else if (ang_step == 17'sd0) begin
        st_next.sw = SW_STILL;
      end else if ((ang_step[16] == adiff[16])) begin
        // A step with the same sign as the gap widens it.
        st_next.sw = SW_DEPARTING;
      end else begin
        st_next.sw = SW_ENCLOSING;
      end
    end
    // Sync-ok and blocked from the onset and the sampled blocking level.
    st_next.sync_prev = sync_now;
    if (!sync_now) begin
      st_next.sync_good = 1'b0;
      st_next.blocked = 1'b0;
    end else if (st_reg.blk) begin
      // A block at the onset latches blocked; a later one only drops sync-ok.
      st_next.sync_good = 1'b0;
      if (!st_reg.sync_prev) begin
        st_next.blocked = 1'b1;
      end
    end else if (!st_reg.blocked) begin
      st_next.sync_good = 1'b1;
    end
    // Stage forcing overrides the result when globally enabled.
    if (st_reg.ctrl[CTRL_FORCE_EN_BIT]) begin
      case (scs_force_t'(st_reg.ctrl[CTRL_FORCE_LSB +: 2]))
        FORCE_BLOCKED: begin
          st_next.sync_good = 1'b0;
          st_next.blocked = 1'b1;
        end
        FORCE_OK: begin
          st_next.sync_good = 1'b1;
          st_next.blocked = 1'b0;
        end
        default: begin
          // Normal: the result stands as computed.
        end
      endcase
    end
    // Condition code: outcome first, then bypass when disabled, else first passing vcond, magnitude or angle check, else frequency ok without testing it.
    if (st_next.blocked) begin
      st_next.cond = COND_BLOCKED;
    end else if (st_next.sync_good) begin
      st_next.cond = COND_OK;
    end else if (!enable) begin
      st_next.cond = COND_BYPASS;
    end else if (vcond_ok) begin
      st_next.cond = COND_VCOND_OK;
    end else if (mag_ok) begin
      st_next.cond = COND_MAG_OK;
    end else if (ang_ok) begin
      st_next.cond = COND_ANG_OK;
    end else begin
      st_next.cond = COND_FRQ_OK;
    end
    // APB slave with zero wait states; unmapped addresses error.
    st_next.pready = PSEL && !PENABLE;
    st_next.pslverr = 1'b0;
    if (PSEL && !PENABLE) begin
      // Read data is taken at setup and stands until the next setup.
      st_next.prdata = 32'h0000_0000;
      case (PADDR)
        OFS_CTRL: st_next.prdata = st_reg.ctrl;
        OFS_MAG_MAX: st_next.prdata = {16'h0000, st_reg.mag_max};
        OFS_ANG_MAX: st_next.prdata = {16'h0000, st_reg.ang_max};
        OFS_FRQ_MAX: st_next.prdata = {16'h0000, st_reg.frq_max};
        OFS_LIVE_THR: st_next.prdata = {16'h0000, st_reg.live_thr};
        OFS_DEAD_THR: st_next.prdata = {16'h0000, st_reg.dead_thr};
        OFS_STATUS: st_next.prdata = {22'h0, st_reg.sw, st_reg.vstate, st_reg.cond,
          st_reg.blocked, st_reg.sync_good};
        OFS_MAG_DIFF: st_next.prdata = 32'(st_reg.mag_diff);
        OFS_ANG_DIFF: st_next.prdata = 32'(st_reg.ang_diff);
        OFS_FRQ_DIFF: st_next.prdata = 32'(st_reg.frq_diff);
        OFS_CLOSE_TIME: st_next.prdata = {15'h0, st_reg.close_time};
        OFS_ROT_TIME: st_next.prdata = {15'h0, st_reg.rot_time};
        OFS_PLACEMENT: st_next.prdata = 32'(st_reg.placement);
        default: st_next.pslverr = 1'b1;
      endcase
    end
    // Writes take effect at the access edge.
    // Status and measurement words are read-only; writes to them are dropped.
    if (PSEL && PENABLE && st_reg.pready && PWRITE) begin
      case (PADDR)
        OFS_CTRL: st_next.ctrl = {20'h0, PWDATA[11:0]};
        OFS_MAG_MAX: st_next.mag_max = PWDATA[15:0];
        OFS_ANG_MAX: st_next.ang_max = PWDATA[15:0];
        OFS_FRQ_MAX: st_next.frq_max = PWDATA[15:0];
        OFS_LIVE_THR: st_next.live_thr = PWDATA[15:0];
        OFS_DEAD_THR: st_next.dead_thr = PWDATA[15:0];
        default: begin
        end
      endcase
    end
    // Ready and error stand for the access cycle only.
    if (PSEL && PENABLE && st_reg.pready) begin
      st_next.pready = 1'b0;
      st_next.pslverr = 1'b0;
    end
  end

  // Register the whole state.
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      st_reg <= '0;
      st_reg.ctrl <= CTRL_RESET;
      st_reg.mag_max <= MAG_MAX_RESET;
      st_reg.ang_max <= ANG_MAX_RESET;
      st_reg.frq_max <= FRQ_MAX_RESET;
      st_reg.live_thr <= LIVE_THR_RESET;
      st_reg.dead_thr <= DEAD_THR_RESET;
      st_reg.cond <= COND_BYPASS;
      st_reg.vstate <= VST_NOT_MON;
      st_reg.sw <= SW_NONE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flip-flops.
  assign PRDATA = st_reg.prdata;
  assign PREADY = st_reg.pready;
  assign PSLVERR = st_reg.pslverr;
  assign SYNC_GOOD_OUT = st_reg.sync_good;
  assign BLOCKED_OUT = st_reg.blocked;

endmodule : scs_stage

// ===== shared/scs_pkg.sv
// Package with constants and types for the synchronism-check stage.
package scs_pkg;

  // Program-cycle clock rate in kHz and the measurement time base.
  localparam int CLK_KHZ = 100000;
  localparam int MEAS_TIME_BASE_MS = 5;
  localparam int MEAS_TIME_BASE_CYC = MEAS_TIME_BASE_MS * CLK_KHZ;

  // APB register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MAG_MAX = 8'h04;
  localparam logic [7:0] OFS_ANG_MAX = 8'h08;
  localparam logic [7:0] OFS_FRQ_MAX = 8'h0c;
  localparam logic [7:0] OFS_LIVE_THR = 8'h10;
  localparam logic [7:0] OFS_DEAD_THR = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_MAG_DIFF = 8'h1c;
  localparam logic [7:0] OFS_ANG_DIFF = 8'h20;
  localparam logic [7:0] OFS_FRQ_DIFF = 8'h24;
  localparam logic [7:0] OFS_CLOSE_TIME = 8'h28;
  localparam logic [7:0] OFS_ROT_TIME = 8'h2c;
  localparam logic [7:0] OFS_PLACEMENT = 8'h30;

  // Control register field positions.
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_START_ON_BIT = 1;
  localparam int CTRL_LINE_REF_BIT = 2;
  localparam int CTRL_TIMED_CLOSE_BIT = 3;
  localparam int CTRL_FORCE_EN_BIT = 4;
  localparam int CTRL_FORCE_LSB = 5;
  localparam int CTRL_VCOND_LSB = 8;

  // Reset values of the settings.
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] MAG_MAX_RESET = 16'h01f4;
  localparam logic [15:0] ANG_MAX_RESET = 16'h03e8;
  localparam logic [15:0] FRQ_MAX_RESET = 16'h0064;
  localparam logic [15:0] LIVE_THR_RESET = 16'h1f40;
  localparam logic [15:0] DEAD_THR_RESET = 16'h07d0;

  // Scaling of the switching estimates.
  localparam int FULL_TURN_CDEG = 36000;
  localparam int MS_PER_STEP = 5;
  localparam logic [16:0] TIME_MAX_STEPS = 17'h11940;

  // Condition code values.
  typedef enum logic [2:0] {
    COND_BLOCKED = 3'h0,
    COND_OK = 3'h1,
    COND_BYPASS = 3'h2,
    COND_VCOND_OK = 3'h3,
    COND_MAG_OK = 3'h4,
    COND_ANG_OK = 3'h5,
    COND_FRQ_OK = 3'h6
  } scs_cond_t;

  // Voltage state of the two sides.
  typedef enum logic [2:0] {
    VST_DEAD_DEAD = 3'h0,
    VST_LIVE_DEAD = 3'h1,
    VST_DEAD_LIVE = 3'h2,
    VST_LIVE_LIVE = 3'h3,
    VST_UNDEFINED = 3'h4,
    VST_NOT_MON = 3'h5
  } scs_vstate_t;

  // Switching state.
  typedef enum logic [1:0] {
    SW_NONE = 2'h0,
    SW_STILL = 2'h1,
    SW_DEPARTING = 2'h2,
    SW_ENCLOSING = 2'h3
  } scs_sw_t;

  // Force selection.
  typedef enum logic [1:0] {
    FORCE_NORMAL = 2'h0,
    FORCE_BLOCKED = 2'h1,
    FORCE_OK = 2'h2
  } scs_force_t;

endpackage : scs_pkg

// ===== logic/scs_side_class.sv
`timescale 1ns/1ps
// Live/dead classifier for one measured voltage.
module scs_side_class
  import scs_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Measurement and thresholds.
  input wire logic [15:0] volt,
  input wire logic [15:0] live_thr,
  input wire logic [15:0] dead_thr,
  // Classification results.
  output logic live,
  output logic dead
);

  // Registered state of the classifier.
  typedef struct packed {
    logic live;
    logic dead;
  } scs_cls_t;

  scs_cls_t st_reg; // Present classification.
  scs_cls_t st_next; // Next classification.

  // Compare against both thresholds; between them the side is neither.
  always_comb begin
    st_next.live = volt > live_thr;
    st_next.dead = volt < dead_thr;
  end

  // Register the classification once per program cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign live = st_reg.live;
  assign dead = st_reg.dead;

endmodule : scs_side_class

// ===== dv/scs_stage_checker.sv
// Port checker for the synchronism-check stage, bound to the stage.
`timescale 1ns/1ps
module scs_stage_checker (
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RESET,
  // APB slave side.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Blocking input and stage results.
  input wire logic BLOCK_IN,
  input wire logic SYNC_GOOD_OUT,
  input wire logic BLOCKED_OUT
);
  // Every check runs on the program-cycle clock and sleeps in reset.
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  // A setup cycle is answered in the very next cycle.
  property p_ready_next; PSEL && !PENABLE |=> PREADY; endproperty
  a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
  // The answer stands for one cycle only.
  property p_ready_pulse; PREADY |=> !PREADY; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
  // A refused access returns zero data.
  property p_err_zero; PREADY && PSLVERR |-> PRDATA == 32'h0; endproperty
  a_err_zero: assert property (p_err_zero) else $error("error with nonzero data");
  // Aligned addresses up to the last register are accepted.
  property p_mapped_ok;
    PSEL && !PENABLE && PADDR <= 8'h30 && PADDR[1:0] == 2'h0 |=> PREADY && !PSLVERR;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok) else $error("mapped address refused");
  // Addresses past the last register are refused.
  property p_unmapped_err; PSEL && !PENABLE && PADDR > 8'h30 |=> PREADY && PSLVERR; endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped accepted");
  // The two results never stand together.
  property p_excl; !(SYNC_GOOD_OUT && BLOCKED_OUT); endproperty
  a_excl: assert property (p_excl) else $error("sync good and blocked together");
  // A sustained block keeps the sync-good output low.
  property p_block_hold; BLOCK_IN [*5] |-> !SYNC_GOOD_OUT; endproperty
  a_block_hold: assert property (p_block_hold) else $error("sync good while blocked");
  // Blocked only starts where sync-good was not already standing.
  property p_blocked_onset; $rose(BLOCKED_OUT) |-> !$past(SYNC_GOOD_OUT); endproperty
  a_blocked_onset: assert property (p_blocked_onset) else $error("blocked after sync good");
endmodule : scs_stage_checker

bind scs_stage scs_stage_checker i_chk (.REF_CLK(REF_CLK), .RESET(RESET), .PSEL(PSEL),
  .PENABLE(PENABLE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .BLOCK_IN(BLOCK_IN), .SYNC_GOOD_OUT(SYNC_GOOD_OUT), .BLOCKED_OUT(BLOCKED_OUT));

// ===== dv/scs_meas_src.sv
// Model of the voltage measurement front end feeding the stage.
`timescale 1ns/1ps
module scs_meas_src #(
  parameter int PERIOD = 50
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Values the next update should deliver.
  input wire logic [15:0] bus_mag_t,
  input wire logic [15:0] line_mag_t,
  input wire logic signed [15:0] line_ang_t,
  input wire logic signed [19:0] line_frq_t,
  // Measurements towards the stage.
  output logic [15:0] bus_mag,
  output logic [15:0] line_mag,
  output logic signed [15:0] bus_ang,
  output logic signed [15:0] line_ang,
  output logic signed [19:0] bus_frq,
  output logic signed [19:0] line_frq,
  output logic meas_valid
);
  logic [15:0] cnt; // Cycles since the last update.
  // The bus side is the steady reference at zero angle and 50 Hz.
  assign bus_ang = 16'sh0;
  assign bus_frq = 20'sh0c350;
  // New fundamental values arrive together once per time base.
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= 16'h0;
      meas_valid <= 1'b0;
      bus_mag <= 16'h0;
      line_mag <= 16'h0;
      line_ang <= 16'sh0;
      line_frq <= 20'sh0;
    end else begin
      meas_valid <= (cnt == 16'(PERIOD - 1));
      cnt <= (cnt == 16'(PERIOD - 1)) ? 16'h0 : cnt + 16'h1;
      if (cnt == 16'(PERIOD - 1)) begin
        bus_mag <= bus_mag_t;
        line_mag <= line_mag_t;
        line_ang <= line_ang_t;
        line_frq <= line_frq_t;
      end
    end
  end
endmodule : scs_meas_src

// ===== dv/scs_stage_bench.sv
// Self-checking bench for the synchronism-check stage.
`timescale 1ns/1ps
module scs_stage_bench;
  import scs_pkg::*;
  localparam int MPER = 50; // Shortened measurement period.
  logic REF_CLK = 0, RESET = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [7:0] PADDR = 8'h0;
  logic [31:0] PWDATA = 32'h0, PRDATA, q;
  logic PREADY, PSLVERR, e, MEAS_VALID, SYNC_GOOD_OUT, BLOCKED_OUT;
  logic BLOCK_IN = 0, CHECK_START_INPUT = 0;
  logic [15:0] BUS_MAG, LINE_MAG, t_bmag = 16'h2710, t_lmag = 16'h2710;
  logic signed [15:0] BUS_ANG, LINE_ANG, t_lang = 16'sh0;
  logic signed [19:0] BUS_FRQ, LINE_FRQ, t_lfrq = 20'sh0c350;
  int failures = 0, n_checks = 0, cyc = 0;
  // Six register offsets with their reset words.
  logic [7:0] ofs [6] = '{OFS_CTRL, OFS_MAG_MAX, OFS_ANG_MAX, OFS_FRQ_MAX, OFS_LIVE_THR,
    OFS_DEAD_THR};
  logic [31:0] rv [6] = '{32'h0, 32'h1f4, 32'h3e8, 32'h64, 32'h1f40, 32'h7d0};
  // Difference cases: just inside and just outside each limit.
  logic [15:0] cm [6] = '{16'h28fd, 16'h2905, 16'h2710, 16'h2710, 16'h2710, 16'h2710};
  logic signed [15:0] ca [6] = '{16'sh0, 16'sh0, 16'sh3e7, 16'sh3e9, 16'sh0, 16'sh0};
  logic signed [19:0] cf [6] = '{20'sh0c350, 20'sh0c350, 20'sh0c350, 20'sh0c350,
    20'sh0c3b3, 20'sh0c3b5};
  // Force cases: control word, line magnitude, expected sync-good.
  logic [31:0] fc [3] = '{32'hf31, 32'hf51, 32'hf41};
  logic [15:0] fm [3] = '{16'h2710, 16'h2ee0, 16'h2ee0};
  logic fx [3] = '{1'b0, 1'b1, 1'b0};

  // Clock at 100 MHz.
  always #5 REF_CLK = ~REF_CLK;

  scs_meas_src #(.PERIOD(MPER)) i_src (.clk(REF_CLK), .rst(RESET), .bus_mag_t(t_bmag),
    .line_mag_t(t_lmag), .line_ang_t(t_lang), .line_frq_t(t_lfrq), .bus_mag(BUS_MAG),
    .line_mag(LINE_MAG), .bus_ang(BUS_ANG), .line_ang(LINE_ANG), .bus_frq(BUS_FRQ),
    .line_frq(LINE_FRQ), .meas_valid(MEAS_VALID));

  scs_stage i_dut (.REF_CLK(REF_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .BUS_MAG(BUS_MAG), .LINE_MAG(LINE_MAG), .BUS_ANG(BUS_ANG),
    .LINE_ANG(LINE_ANG), .BUS_FRQ(BUS_FRQ), .LINE_FRQ(LINE_FRQ), .MEAS_VALID(MEAS_VALID),
    .BLOCK_IN(BLOCK_IN), .CHECK_START_INPUT(CHECK_START_INPUT),
    .SYNC_GOOD_OUT(SYNC_GOOD_OUT), .BLOCKED_OUT(BLOCKED_OUT));

  // Prints the verdict and ends the run.
  task automatic tally_and_finish;
    if (failures == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // Compares a word.
  task automatic chk32(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, x, g);
    end
  endtask : chk32

  // Compares a single bit.
  task automatic chk1(input string nm, input logic x, input logic g);
    n_checks++;
    if (g !== x) begin
      failures++;
      $display("mismatch %s expected %b seen %b", nm, x, g);
    end
  endtask : chk1

  // One APB transfer, entered just after a rising edge, then one idle cycle.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    @(posedge REF_CLK);
    while (PREADY !== 1'b1) begin
      @(posedge REF_CLK);
    end
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge REF_CLK);
  endtask : apb

  // Reads a register and compares the word, expecting no error.
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk1("pslverr", 1'b0, e);
    chk32(nm, x, q);
  endtask : rd_chk

  // Lets a fresh measurement reach the results.
  task automatic settle;
    repeat (MPER + 8) @(posedge REF_CLK);
  endtask : settle

  // Cuts a hang short.
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      tally_and_finish();
    end
  end

  // Main sequence.
  initial begin
    repeat (10) @(posedge REF_CLK);
    RESET <= 1'b0;
    for (int i = 0; i < 6; i++) rd_chk("reset_value", ofs[i], rv[i]);
    apb(1'b0, 8'h40, 32'h0);
    chk1("unmapped_err", 1'b1, e);
    chk32("unmapped_data", 32'h0, q);
    apb(1'b1, OFS_STATUS, 32'hffff_ffff);
    rd_chk("status_off", OFS_STATUS, 32'ha8);
    apb(1'b1, OFS_CTRL, 32'hf01);
    settle();
    chk1("sync_good", 1'b1, SYNC_GOOD_OUT);
    rd_chk("status_ok", OFS_STATUS, 32'h65);
    rd_chk("mag_diff", OFS_MAG_DIFF, 32'h0);
    rd_chk("ang_diff", OFS_ANG_DIFF, 32'h0);
    rd_chk("frq_diff", OFS_FRQ_DIFF, 32'h0);
    for (int i = 0; i < 6; i++) begin
      t_lmag <= cm[i];
      t_lang <= ca[i];
      t_lfrq <= cf[i];
      settle();
      chk1("sync_window", i % 2 == 0, SYNC_GOOD_OUT);
      if (i == 0) begin
        rd_chk("mag_diff_size", OFS_MAG_DIFF, 32'hffff_fe13);
      end
      if (i == 2) begin
        rd_chk("ang_diff_size", OFS_ANG_DIFF, 32'hffff_fc19);
        rd_chk("placement", OFS_PLACEMENT, 32'hffff_d8fa);
        rd_chk("rot_time_max", OFS_ROT_TIME, {15'h0, TIME_MAX_STEPS});
        rd_chk("close_time_max", OFS_CLOSE_TIME, {15'h0, TIME_MAX_STEPS});
      end
      if (i == 4) begin
        rd_chk("frq_diff_size", OFS_FRQ_DIFF, 32'hffff_ff9d);
      end
    end
    t_lang <= 16'sh0;
    t_lfrq <= 20'sh0c350;
    t_bmag <= 16'h03e8;
    t_lmag <= 16'h03e8;
    apb(1'b1, OFS_CTRL, 32'h801);
    settle();
    chk1("dead_not_allowed", 1'b0, SYNC_GOOD_OUT);
    apb(1'b1, OFS_CTRL, 32'h101);
    settle();
    rd_chk("status_dead_dead", OFS_STATUS, 32'h05);
    t_bmag <= 16'h1388;
    t_lmag <= 16'h1388;
    settle();
    apb(1'b0, OFS_STATUS, 32'h0);
    chk32("vstate_undefined", 32'h4, {29'h0, q[7:5]});
    t_bmag <= 16'h2710;
    t_lmag <= 16'h2710;
    apb(1'b1, OFS_CTRL, 32'hf03);
    settle();
    chk1("start_absent", 1'b0, SYNC_GOOD_OUT);
    CHECK_START_INPUT <= 1'b1;
    settle();
    chk1("start_present", 1'b1, SYNC_GOOD_OUT);
    BLOCK_IN <= 1'b1;
    repeat (8) @(posedge REF_CLK);
    chk1("late_block_sync", 1'b0, SYNC_GOOD_OUT);
    chk1("late_block_flag", 1'b0, BLOCKED_OUT);
    BLOCK_IN <= 1'b0;
    t_lmag <= 16'h2ee0;
    settle();
    BLOCK_IN <= 1'b1;
    repeat (4) @(posedge REF_CLK);
    t_lmag <= 16'h2710;
    settle();
    chk1("early_block_flag", 1'b1, BLOCKED_OUT);
    chk1("early_block_sync", 1'b0, SYNC_GOOD_OUT);
    BLOCK_IN <= 1'b0;
    repeat (8) @(posedge REF_CLK);
    chk1("blocked_latched", 1'b1, BLOCKED_OUT);
    t_lmag <= 16'h2ee0;
    settle();
    chk1("blocked_cleared", 1'b0, BLOCKED_OUT);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, OFS_CTRL, fc[i]);
      t_lmag <= fm[i];
      settle();
      chk1("forced_sync", fx[i], SYNC_GOOD_OUT);
    end
    t_lmag <= 16'h2710;
    apb(1'b1, OFS_CTRL, 32'hf09);
    settle();
    apb(1'b0, OFS_STATUS, 32'h0);
    chk32("switch_state_still", 32'h1, {30'h0, q[9:8]});
    t_lang <= 16'sh2328;
    t_lfrq <= 20'sh0c3b4;
    settle();
    rd_chk("close_time", OFS_CLOSE_TIME, 32'h1f4);
    rd_chk("rot_time", OFS_ROT_TIME, 32'h7d0);
    tally_and_finish();
  end
endmodule : scs_stage_bench
